// ---- hdl/als_pkg.sv ----
// constants and types shared by both ends of the sensor link
package als_pkg;
  // ==================================================================
  // link addressing and timing
  localparam logic [6:0] TARGET_ADDR = 7'h44;
  localparam int CLK_HZ = 50_000_000;
  localparam int SCL_HZ = 400_000;
  // quarter of an scl period; a least time, so it rounds up
  localparam int SCL_QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);

  // ==================================================================
  // sensor register indices and values after reset
  localparam logic [7:0] IDX_DEV_ID = 8'h00;
  localparam logic [7:0] IDX_PROX = 8'h01;
  localparam logic [7:0] IDX_SENSE = 8'h02;
  localparam logic [7:0] IDX_IR_TRIM = 8'h03;
  localparam logic [7:0] IDX_IRQ = 8'h04;
  localparam logic [7:0] PROX_RST = 8'h00;
  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam logic [7:0] IR_TRIM_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h10;
  localparam logic [7:0] PROX_RW_MASK = 8'h3f;
  localparam logic [7:0] IR_TRIM_RW_MASK = 8'h1f;
  localparam logic [7:0] IRQ_RW_MASK = 8'h67;
  localparam logic [7:0] IRQ_PWR_MASK = 8'h10;

  // ==================================================================
  // sensor field positions
  localparam int ID_LSB = 3;
  localparam int PROX_ON_BIT = 5;
  localparam int IDLE_LSB = 2;
  localparam int CURRENT_LSB = 0;
  localparam int STYLE_BIT = 7;
  localparam int BIAS_LSB = 3;
  localparam int LIGHT_ON_BIT = 2;
  localparam int SCALE_LSB = 0;
  localparam int IRT_LSB = 0;
  localparam int IRQ_PFLAG_BIT = 7;
  localparam int IRQ_PPERS_LSB = 5;
  localparam int IRQ_LFLAG_BIT = 3;
  localparam int IRQ_LPERS_LSB = 1;
  localparam int IRQ_AND_BIT = 0;

  // ==================================================================
  // controller registers on the system bus
  localparam logic [7:0] CTL_CMD_OFS = 8'h00;
  localparam logic [7:0] CTL_TXD_OFS = 8'h04;
  localparam logic [7:0] CTL_RXD_OFS = 8'h08;
  localparam logic [7:0] CTL_STAT_OFS = 8'h0c;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_CNT_LSB = 16;
  localparam logic [2:0] MAX_BYTES = 3'h4;

  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_INDEX, D_WDATA, D_RDATA, D_IGNORE
  } als_dev_state_e;
  typedef enum logic [1:0] {C_IDLE, C_START, C_BIT, C_STOP} als_ctl_state_e;
  typedef enum logic [1:0] {P_ADDR, P_INDEX, P_DATA} als_part_e;
endpackage

// ---- hdl/als_i2c_if.sv ----
// two-wire link between the controller end and the sensor end
`timescale 1ns/1ps
interface als_i2c_if;
  logic scl;
  logic sda;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda_ctl_o;
  logic sda_ctl_oe;

  // ==================================================================
  // wired-and with pull-up: any enabled driver showing 0 pulls low
  assign sda = ~((sda_dev_oe & ~sda_dev_o) | (sda_ctl_oe & ~sda_ctl_o));

  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport ctl (output scl, input sda, output sda_ctl_o, output sda_ctl_oe);
endinterface

// ---- hdl/als_sync.sv ----
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
module als_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1) begin : g_chk
    $error("als_sync: WIDTH must be at least 1");
  end

  // ==================================================================
  // idle bus lines are high, so both stages reset high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end
  assign dout = sync_reg;
endmodule

// ---- hdl/als_dev.sv ----
// sensor end: link target, configuration registers, interrupt pin
`timescale 1ns/1ps
// Operation
// RL1: answer only target address 1000100
// RL2: controller opens each frame with START
// RL3: first byte is seven address bits plus direction
// RL4: target pulls data low on each ack
// RL5: only controller drives clock; data either side
// RL6: controller closes each frame with STOP
// RL7: single and multi-byte reads and writes
// RL8: no repeated START; STOP between index, read
// RL9: index 0 read-only, part code in 7:3
// RL10: proximity_on bit 5 enables proximity
// RL11: idle period field selects measurement wait
// RL12: emitter current select in bits 1:0
// RL13: bit 7 picks hysteresis or window compare
// RL14: bits 6:3 hold proximity bias trim
// RL15: light_sense_on bit 2 enables light
// RL16: bits 1:0 select light full scale
// RL17: bits 4:0 hold infrared trim
// RL18: reset values 00,00,00 and 10
// RL19: combine bit selects and/or of events
// RL20: persistence needs 1,2,4,8 consecutive events
// RL21: write carries index then data, index increments
// RL22: writes to identification acked, then ignored
module als_dev
  import als_pkg::*;
#(
  parameter logic [4:0] PART_ID = 5'h0a  // arbitrary value
) (
  input wire logic hclk,
  input wire logic hresetn,
  als_i2c_if.dev link,
  input wire logic prox_meas,
  input wire logic prox_hit,
  input wire logic light_meas,
  input wire logic light_hit,
  output logic proximity_on,
  output logic [2:0] proximity_idle_period,
  output logic [1:0] emitter_current_select,
  output logic irq_compare_style,
  output logic [3:0] proximity_bias_trim,
  output logic light_sense_on,
  output logic [1:0] light_full_scale,
  output logic [4:0] light_infrared_trim,
  output logic irq_n
);
  // ==================================================================
  // pin sampling and bus condition detection
  logic [1:0] pin_s;
  logic scl_d_reg;
  logic sda_d_reg;
  als_sync #(.WIDTH(2)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din({link.scl, link.sda}),
    .dout(pin_s)
  );
  wire scl_s = pin_s[1];
  wire sda_s = pin_s[0];
  // the clock is only ever sampled, never driven from this end
  wire scl_rise = scl_s & ~scl_d_reg;  // RL5
  wire scl_fall = ~scl_s & scl_d_reg;
  wire clk_high = scl_s & scl_d_reg;
  wire start_seen = clk_high & sda_d_reg & ~sda_s;  // RL2
  wire stop_seen = clk_high & ~sda_d_reg & sda_s;  // RL6

  // ==================================================================
  // frame state
  als_dev_state_e state_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [7:0] idx_reg;
  logic read_reg;
  logic mack_reg;
  logic oe_reg;
  logic out_reg;

  // ==================================================================
  // configuration and interrupt state
  logic [7:0] prox_reg;
  logic [7:0] sense_reg;
  logic [7:0] irt_reg;
  logic [7:0] irq_cfg_reg;
  logic pflag_reg;
  logic lflag_reg;
  logic [3:0] pcnt_reg;
  logic [3:0] lcnt_reg;
  logic irq_n_reg;

  // ==================================================================
  // byte slot decode
  wire addr_hit = sh_reg[7:1] == TARGET_ADDR;  // RL1 RL3
  wire ack_slot = scl_fall & (bit_reg == 4'd8);
  wire end_slot = scl_fall & (bit_reg == 4'd9);
  wire in_rx = (state_reg == D_ADDR) | (state_reg == D_INDEX) |
               (state_reg == D_WDATA);
  wire wr_strobe = ack_slot & (state_reg == D_WDATA);
  wire rd_done = ack_slot & (state_reg == D_RDATA);
  wire irq_clr = rd_done & (idx_reg == IDX_IRQ);
  logic [7:0] irq_val;
  logic [7:0] rd_data;

  // flags live outside the stored byte and are merged on read
  assign irq_val = irq_cfg_reg | (8'(pflag_reg) << IRQ_PFLAG_BIT) |
                   (8'(lflag_reg) << IRQ_LFLAG_BIT);

  // read selection; reserved and unmapped bits read zero
  always_comb begin
    case (idx_reg)
      IDX_DEV_ID: rd_data = 8'(PART_ID) << ID_LSB;  // RL9
      IDX_PROX: rd_data = prox_reg;
      IDX_SENSE: rd_data = sense_reg;
      IDX_IR_TRIM: rd_data = irt_reg;
      IDX_IRQ: rd_data = irq_val;
      default: rd_data = 8'h00;
    endcase
  end

  // ==================================================================
  // persistence: {fire, next count}; count saturates at the need
  function automatic logic [4:0] persist(input logic [3:0] cnt,
                                         input logic [1:0] code,
                                         input logic hit);
    logic [3:0] need;
    logic [3:0] nxt;
    need = 4'd1 << code;
    nxt = (cnt >= need) ? need : cnt + 4'd1;
    persist = hit ? {nxt >= need, nxt} : 5'h00;
  endfunction

  wire [4:0] p_upd = persist(pcnt_reg, irq_cfg_reg[IRQ_PPERS_LSB +: 2],
                             prox_hit);  // RL20
  wire [4:0] l_upd = persist(lcnt_reg, irq_cfg_reg[IRQ_LPERS_LSB +: 2],
                             light_hit);  // RL20

  // event flags; a new event wins over the clear by readout
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pcnt_reg <= 4'h0;
      lcnt_reg <= 4'h0;
      pflag_reg <= 1'b0;
      lflag_reg <= 1'b0;
      irq_n_reg <= 1'b1;
    end else begin
      if (prox_meas) pcnt_reg <= p_upd[3:0];
      if (light_meas) lcnt_reg <= l_upd[3:0];
      if (prox_meas & p_upd[4]) pflag_reg <= 1'b1;
      else if (irq_clr) pflag_reg <= 1'b0;
      if (light_meas & l_upd[4]) lflag_reg <= 1'b1;
      else if (irq_clr) lflag_reg <= 1'b0;
      irq_n_reg <= irq_cfg_reg[IRQ_AND_BIT] ? ~(pflag_reg & lflag_reg) :
                   ~(pflag_reg | lflag_reg);  // RL19
    end
  end

  // ==================================================================
  // register writes; the power alarm only clears by writing zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prox_reg <= PROX_RST;  // RL18
      sense_reg <= SENSE_RST;  // RL18
      irt_reg <= IR_TRIM_RST;  // RL18
      irq_cfg_reg <= IRQ_RST;  // RL18
    end else if (wr_strobe) begin
      case (idx_reg)
        IDX_PROX: prox_reg <= sh_reg & PROX_RW_MASK;  // RL10
        IDX_SENSE: sense_reg <= sh_reg;  // RL13 RL14 RL15 RL16
        IDX_IR_TRIM: irt_reg <= sh_reg & IR_TRIM_RW_MASK;  // RL17
        IDX_IRQ: irq_cfg_reg <= (sh_reg & IRQ_RW_MASK) |
                                (irq_cfg_reg & sh_reg & IRQ_PWR_MASK);
        default: ;  // RL22
      endcase
    end
  end

  // ==================================================================
  // frame sequencer; a start inside a frame parks until stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= D_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      idx_reg <= 8'h00;
      read_reg <= 1'b0;
      mack_reg <= 1'b0;
      oe_reg <= 1'b0;
      out_reg <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      if (stop_seen) begin
        state_reg <= D_IDLE;
        oe_reg <= 1'b0;
      end else if (start_seen) begin
        oe_reg <= 1'b0;
        bit_reg <= 4'h0;
        state_reg <= (state_reg == D_IDLE) ? D_ADDR : D_IGNORE;  // RL8
      end else if (in_rx) begin
        if (scl_rise & (bit_reg < 4'd8)) begin
          sh_reg <= {sh_reg[6:0], sda_s};  // RL3
          bit_reg <= bit_reg + 4'd1;
        end else if (ack_slot) begin
          if ((state_reg == D_ADDR) & ~addr_hit) begin
            state_reg <= D_IGNORE;  // RL1
          end else begin
            oe_reg <= 1'b1;  // RL4
            out_reg <= 1'b0;
            bit_reg <= 4'd9;
          end
          if (state_reg == D_ADDR) read_reg <= sh_reg[0];  // RL3
          if (state_reg == D_INDEX) idx_reg <= sh_reg;  // RL21
          if (state_reg == D_WDATA) idx_reg <= idx_reg + 8'd1;  // RL21
        end else if (end_slot) begin
          bit_reg <= 4'h0;
          oe_reg <= 1'b0;
          if ((state_reg == D_ADDR) & read_reg) begin
            state_reg <= D_RDATA;  // RL7
            sh_reg <= rd_data;
            oe_reg <= 1'b1;
            out_reg <= rd_data[7];
          end else if (state_reg == D_ADDR) begin
            state_reg <= D_INDEX;
          end else begin
            state_reg <= D_WDATA;  // RL7
          end
        end
      end else if (state_reg == D_RDATA) begin
        if (scl_rise) begin
          bit_reg <= bit_reg + 4'd1;
          if (bit_reg == 4'd8) mack_reg <= ~sda_s;
        end else if (scl_fall & (bit_reg < 4'd8)) begin
          sh_reg <= {sh_reg[6:0], 1'b0};
          out_reg <= sh_reg[6];
        end else if (ack_slot) begin
          oe_reg <= 1'b0;  // let the controller answer
          idx_reg <= idx_reg + 8'd1;  // RL7
        end else if (end_slot) begin
          bit_reg <= 4'h0;
          if (mack_reg) begin
            sh_reg <= rd_data;
            oe_reg <= 1'b1;
            out_reg <= rd_data[7];
          end else begin
            state_reg <= D_IGNORE;
          end
        end
      end
    end
  end

  // ==================================================================
  // outputs, all from flops
  assign link.sda_dev_oe = oe_reg;  // RL5
  assign link.sda_dev_o = out_reg;
  assign proximity_on = prox_reg[PROX_ON_BIT];  // RL10
  assign proximity_idle_period = prox_reg[IDLE_LSB +: 3];  // RL11
  assign emitter_current_select = prox_reg[CURRENT_LSB +: 2];  // RL12
  assign irq_compare_style = sense_reg[STYLE_BIT];  // RL13
  assign proximity_bias_trim = sense_reg[BIAS_LSB +: 4];  // RL14
  assign light_sense_on = sense_reg[LIGHT_ON_BIT];  // RL15
  assign light_full_scale = sense_reg[SCALE_LSB +: 2];  // RL16
  assign light_infrared_trim = irt_reg[IRT_LSB +: 5];  // RL17
  assign irq_n = irq_n_reg;
endmodule

// ---- hdl/als_ctl.sv ----
// controller end: bus command registers and link sequencer
`timescale 1ns/1ps
module als_ctl
  import als_pkg::*;
#(
  parameter int QTR_CYC = SCL_QTR_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  als_i2c_if.ctl link
);
  if ((QTR_CYC < 2) || (QTR_CYC > 65535)) begin : g_chk
    $error("als_ctl: QTR_CYC out of range");
  end

  // ==================================================================
  // state
  als_ctl_state_e state_reg;
  als_part_e part_reg;
  logic sda_s;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  logic cmd_read_reg;
  logic [7:0] cmd_idx_reg;
  logic [2:0] cmd_cnt_reg;
  logic [31:0] txd_reg;
  logic [31:0] rxd_reg;
  logic nack_reg;
  logic [15:0] qcnt_reg;
  logic [1:0] ph_reg;
  logic pass_reg;
  logic restart_reg;
  logic [2:0] nb_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic ack_n_reg;
  logic scl_reg;
  logic oe_reg;

  als_sync #(.WIDTH(1)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din(link.sda),
    .dout(sda_s)
  );

  function automatic logic [7:0] tx_byte(input logic [31:0] d,
                                         input logic [1:0] n);
    tx_byte = d[{n, 3'b000} +: 8];
  endfunction

  // ==================================================================
  // bus decode; commands and tx data are frozen while busy
  wire take = hsel & htrans[1] & hready;
  wire busy = state_reg != C_IDLE;
  wire cmd_wr = wr_pend_reg & (wr_addr_reg == CTL_CMD_OFS) & ~busy;
  wire txd_wr = wr_pend_reg & (wr_addr_reg == CTL_TXD_OFS) & ~busy;
  wire go = cmd_wr & hwdata[CMD_GO_BIT];
  wire [2:0] cnt_in = hwdata[CMD_CNT_LSB +: 3];
  wire rx_data = pass_reg & (part_reg == P_DATA);
  wire last = nb_reg == (cmd_cnt_reg - 3'd1);
  wire tick = busy & (qcnt_reg == 16'(QTR_CYC - 1));
  logic [31:0] rd_mux;

  always_comb begin
    case (haddr[7:0])
      CTL_CMD_OFS: rd_mux = (32'(cmd_cnt_reg) << CMD_CNT_LSB) |
                            (32'(cmd_idx_reg) << CMD_IDX_LSB) |
                            (32'(cmd_read_reg) << CMD_READ_BIT);
      CTL_TXD_OFS: rd_mux = txd_reg;
      CTL_RXD_OFS: rd_mux = rxd_reg;
      CTL_STAT_OFS: rd_mux = {30'h0, nack_reg, busy};
      default: rd_mux = 32'h0;
    endcase
  end

  // zero-wait slave: read data is latched in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
      cmd_read_reg <= 1'b0;
      cmd_idx_reg <= 8'h00;
      cmd_cnt_reg <= 3'h1;
      txd_reg <= 32'h0;
    end else begin
      wr_pend_reg <= take & hwrite;
      wr_addr_reg <= haddr[7:0];
      if (take & ~hwrite) hrdata_reg <= rd_mux;
      if (cmd_wr) begin
        cmd_read_reg <= hwdata[CMD_READ_BIT];
        cmd_idx_reg <= hwdata[CMD_IDX_LSB +: 8];
        cmd_cnt_reg <= (cnt_in == 3'h0) ? 3'h1 :
                       (cnt_in > MAX_BYTES) ? MAX_BYTES : cnt_in;
      end
      if (txd_wr) txd_reg <= hwdata;
    end
  end

  // ==================================================================
  // link sequencer: four quarter phases per bit, scl high in 2 and 3
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= C_IDLE;
      part_reg <= P_ADDR;
      qcnt_reg <= 16'h0;
      ph_reg <= 2'h0;
      pass_reg <= 1'b0;
      restart_reg <= 1'b0;
      nb_reg <= 3'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      ack_n_reg <= 1'b1;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      rxd_reg <= 32'h0;
    end else begin
      qcnt_reg <= (tick | ~busy) ? 16'h0 : qcnt_reg + 16'h1;
      if (go) begin
        state_reg <= C_START;
        part_reg <= P_ADDR;
        ph_reg <= 2'h0;
        pass_reg <= 1'b0;
        restart_reg <= 1'b0;
        nb_reg <= 3'h0;
        nack_reg <= 1'b0;
      end else if (tick) begin
        ph_reg <= ph_reg + 2'h1;
        case (state_reg)
          C_START: begin
            if (ph_reg == 2'h0) begin
              scl_reg <= 1'b1;
              oe_reg <= 1'b0;
            end
            if (ph_reg == 2'h1) oe_reg <= 1'b1;  // RL2
            if (ph_reg == 2'h3) begin
              scl_reg <= 1'b0;
              state_reg <= C_BIT;
              bit_reg <= 4'h0;
              sh_reg <= {TARGET_ADDR, pass_reg};  // RL1 RL3
            end
          end
          C_BIT: begin
            if (ph_reg == 2'h0) begin
              oe_reg <= (bit_reg == 4'd8) ? (rx_data & ~last) :
                        (~rx_data & ~sh_reg[7]);  // RL5
            end
            if (ph_reg == 2'h1) scl_reg <= 1'b1;
            if (ph_reg == 2'h2) begin
              if (bit_reg != 4'd8) sh_reg <= {sh_reg[6:0], sda_s};
              else ack_n_reg <= sda_s;
            end
            if (ph_reg == 2'h3) begin
              scl_reg <= 1'b0;
              bit_reg <= (bit_reg == 4'd8) ? 4'h0 : bit_reg + 4'h1;
              if ((bit_reg == 4'd8) & ~rx_data & ack_n_reg) begin
                nack_reg <= 1'b1;
                restart_reg <= 1'b0;
                state_reg <= C_STOP;
              end else if (bit_reg == 4'd8) begin
                case (part_reg)
                  P_ADDR: begin
                    part_reg <= pass_reg ? P_DATA : P_INDEX;
                    sh_reg <= cmd_idx_reg;  // RL21
                  end
                  P_INDEX: begin
                    if (cmd_read_reg) begin
                      restart_reg <= 1'b1;  // RL8
                      state_reg <= C_STOP;
                    end else begin
                      part_reg <= P_DATA;
                      sh_reg <= tx_byte(txd_reg, 2'h0);  // RL21
                    end
                  end
                  default: begin
                    if (pass_reg) rxd_reg[{nb_reg[1:0], 3'b000} +: 8] <= sh_reg;
                    nb_reg <= nb_reg + 3'h1;
                    sh_reg <= tx_byte(txd_reg, 2'(nb_reg + 3'h1));
                    if (last) state_reg <= C_STOP;
                  end
                endcase
              end
            end
          end
          C_STOP: begin
            if (ph_reg == 2'h0) oe_reg <= 1'b1;
            if (ph_reg == 2'h1) scl_reg <= 1'b1;
            if (ph_reg == 2'h2) oe_reg <= 1'b0;  // RL6
            if (ph_reg == 2'h3) begin
              restart_reg <= 1'b0;
              pass_reg <= restart_reg;
              part_reg <= P_ADDR;
              state_reg <= restart_reg ? C_START : C_IDLE;  // RL8
            end
          end
          default: ;
        endcase
      end
    end
  end

  // ==================================================================
  // outputs, all from flops; data line is open drain, low when enabled
  assign link.scl = scl_reg;  // RL5
  assign link.sda_ctl_oe = oe_reg;
  assign link.sda_ctl_o = 1'b0;
  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
endmodule

// ---- verification/als_link_properties.sv ----
// link checker: wire relations between the two ends
`timescale 1ns/1ps
module als_link_properties
  import als_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda_ctl_o,
  input wire logic sda_ctl_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==================================================================
  // frame tracking
  logic scl_q, sda_q, in_frame, first, rd;
  logic [3:0] nbit;
  logic [7:0] sh;
  // conditions on raw pins, one hclk late
  wire rise = scl & ~scl_q;
  wire start = scl & scl_q & sda_q & ~sda;
  wire stop = scl & scl_q & ~sda_q & sda;
  wire dev_low = sda_dev_oe & ~sda_dev_o;
  wire ack = rise & (nbit == 4'h8);

  // sh holds each byte at its ack slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {scl_q, sda_q, in_frame, first, rd} <= 5'h18;
      nbit <= 4'h0;
      sh <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        in_frame <= 1'b1;
        first <= 1'b1;
        nbit <= 4'h0;
      end else if (stop) begin
        in_frame <= 1'b0;
      end else if (rise) begin
        nbit <= ack ? 4'h0 : nbit + 4'h1;
        if (!ack) sh <= {sh[6:0], sda};
        if (ack) first <= 1'b0;
        if (ack && first) rd <= sh[0];
      end
    end
  end

  // ==================================================================
  // properties
  ctl_open_drain_a: assert property (sda_ctl_o == 1'b0)
    else $error("controller drove data high");
  dev_sda_stable_a: assert property (scl && $past(scl) |-> $stable(dev_low))
    else $error("device moved data while clock high");
  scl_low_min_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  scl_low_max_a: assert property ($fell(scl) |-> ##[1:40] scl)
    else $error("clock held low too long");
  start_by_ctl_a: assert property (start |-> sda_ctl_oe)
    else $error("start not made by controller");
  stop_by_ctl_a: assert property (stop |-> $past(sda_ctl_oe))
    else $error("stop not made by controller");
  addr_form_a: assert property (ack && first |-> sh[7:1] == TARGET_ADDR)
    else $error("first byte not the target address");
  addr_ack_a: assert property (ack && first |-> !sda)
    else $error("address byte not acknowledged");
  write_ack_a: assert property (ack && !first && !rd |-> !sda)
    else $error("written byte not acknowledged");
  scl_idle_a: assert property (!in_frame |-> scl)
    else $error("clock low outside a frame");
  cover property (ack && first && sh[0]);
  cover property (ack && !first && !rd);
  cover property (stop);
endmodule

// ---- verification/als_tb_top.sv ----
// testbench: bus-driven link transfers
`timescale 1ns/1ps
module als_tb_top
  import als_pkg::*;
;
  localparam logic [4:0] ID = 5'h0a; // arbitrary part code
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
  logic hreadyout, hresp, pon, style, lon, irq;
  logic [3:0] ev = 4'h0;
  logic [4:0] trim;
  logic [3:0] bias;
  logic [2:0] idle;
  logic [1:0] cur, scale;
  int num_errors = 0, total_checks = 0, cycles = 0;

  // ==================================================================
  // ends, link and checker
  als_i2c_if link ();
  als_ctl #(.QTR_CYC(8)) i_als_ctl (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link.ctl));
  als_dev #(.PART_ID(ID)) i_als_dev (.hclk(hclk), .hresetn(hresetn),
    .link(link.dev), .prox_meas(ev[3]), .prox_hit(ev[2]), .light_meas(ev[1]),
    .light_hit(ev[0]), .proximity_on(pon), .proximity_idle_period(idle),
    .emitter_current_select(cur), .irq_compare_style(style),
    .proximity_bias_trim(bias), .light_sense_on(lon),
    .light_full_scale(scale), .light_infrared_trim(trim), .irq_n(irq));
  als_link_properties i_als_link_properties (.hclk(hclk),
    .hresetn(hresetn), .scl(link.scl), .sda(link.sda),
    .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
    .sda_ctl_o(link.sda_ctl_o), .sda_ctl_oe(link.sda_ctl_oe));

  // ==================================================================
  // clock and hang guard
  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ==================================================================
  // tasks
  task automatic check(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one word; read data taken as the data phase ends
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdat = hrdata;
  endtask
  // one command, two frames when reading; read bytes left in rdat
  task automatic xfer(input logic rd, input logic [7:0] idx,
                      input logic [2:0] n, input logic [31:0] tx);
    if (!rd) ahb(1'b1, CTL_TXD_OFS, tx);
    ahb(1'b1, CTL_CMD_OFS, {13'h0, n, idx, 6'h0, rd, 1'b1});
    ahb(1'b0, CTL_STAT_OFS, 32'h0);
    while (rdat[0] !== 1'b0) ahb(1'b0, CTL_STAT_OFS, 32'h0);
    check("nack", 32'h0, {30'h0, hresp, rdat[1]});
    if (rd) ahb(1'b0, CTL_RXD_OFS, 32'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==================================================================
  // main sequence
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b1, IDX_DEV_ID, 3'h4, 32'h0);
    check("reset", {IR_TRIM_RST, SENSE_RST, PROX_RST, ID, 3'h0}, rdat);
    xfer(1'b1, IDX_IRQ, 3'h1, 32'h0);
    check("irq reset", {24'h0, IRQ_RST}, {24'h0, rdat[7:0]});
    $display("test reset values done");
    xfer(1'b0, IDX_PROX, 3'h3, 32'h00ffffff);
    xfer(1'b1, IDX_PROX, 3'h3, 32'h0);
    check("cfg read", 32'h1fff3f, {8'h0, rdat[23:0]});
    check("fields", {13'h0, 6'h3f, 8'hff, 5'h1f}, {13'h0, pon, idle, cur,
      style, bias, lon, scale, trim});
    $display("test multi-byte done");
    // second byte lands on index 1
    xfer(1'b0, IDX_DEV_ID, 3'h2, 32'h00000055);
    xfer(1'b1, IDX_DEV_ID, 3'h2, 32'h0);
    check("id kept", {16'h0, 8'h00, ID, 3'h0}, {16'h0, rdat[15:0]});
    $display("test read-only write done");
    xfer(1'b0, IDX_SENSE, 3'h1, 32'h0000005a);
    check("fields 2", {13'h0, 6'h00, 8'h5a, 5'h1f}, {13'h0, pon, idle, cur,
      style, bias, lon, scale, trim});
    xfer(1'b0, IDX_IRQ, 3'h1, 32'h000000ff);
    xfer(1'b1, IDX_IRQ, 3'h1, 32'h0);
    check("irq cfg", 32'h77, {24'h0, rdat[7:0]});
    repeat (8) begin
      @(posedge hclk) ev <= 4'hf;
      @(posedge hclk) ev <= 4'h0;
      @(negedge hclk) check("irq", 32'h1, 32'(irq));
    end
    @(negedge hclk) check("irq", 32'h0, 32'(irq));
    @(posedge hclk) xfer(1'b1, IDX_IRQ, 3'h1, 32'h0);
    check("flags", 32'hff, 32'(rdat[7:0]));
    check("irq", 32'h1, 32'(irq));
    $display("test single-byte done");
    end_of_test();
  end
endmodule
